// ---- hdl/dac_cfg_pkg.sv ----
// Shared constants, field encodings and carrier types of the DAC register bank
package dac_cfg_pkg;

    // ==========================================================
    // Widths and limits
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int MAX_RES = 12;
    localparam int NV_DEPTH = 16;

    // ==========================================================
    // Register locations
    localparam logic [4:0] ADDR_CODE_CH0_V = 5'h00;
    localparam logic [4:0] ADDR_CODE_CH1_V = 5'h01;
    localparam logic [4:0] ADDR_REFSEL_V = 5'h08;
    localparam logic [4:0] ADDR_PWRDN_V = 5'h09;
    localparam logic [4:0] ADDR_GAIN_STAT_V = 5'h0a;
    localparam logic [4:0] ADDR_CODE_CH0_NV = 5'h10;
    localparam logic [4:0] ADDR_CODE_CH1_NV = 5'h11;
    localparam logic [4:0] ADDR_REFSEL_NV = 5'h18;
    localparam logic [4:0] ADDR_PWRDN_NV = 5'h19;
    localparam logic [4:0] ADDR_GAIN_NV = 5'h1a;

    // ==========================================================
    // Field positions and reset values
    localparam int GAIN_LSB = 8;
    localparam int POR_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [2:0] NV_LOAD_COUNT = 3'h5;

    // ==========================================================
    // Field encodings
    typedef enum logic [1:0] {
        REF_VDD = 2'h0,
        REF_BANDGAP = 2'h1,
        REF_PIN_UNBUF = 2'h2,
        REF_PIN_BUF = 2'h3
    } refsel_t;

    typedef enum logic [1:0] {
        PD_NORMAL = 2'h0,
        PD_LOAD_1K = 2'h1,
        PD_LOAD_100K = 2'h2,
        PD_OPEN = 2'h3
    } pwrdn_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [MAX_RES-1:0] code;
        refsel_t refsel;
        pwrdn_t pwrdn;
        logic gain_bit;
    } ch_regs_t;

    typedef struct packed {
        logic vdd_ref;
        logic pin_ref;
        logic bandgap_ref;
        logic ref_buffer_en;
        logic gain_2x;
        logic out_enabled;
        logic pull_1k;
        logic pull_100k;
    } ch_drive_t;

    localparam ch_drive_t DRIVE_RESET = '{vdd_ref: 1'b1, out_enabled: 1'b1, default: 1'b0};

    // ==========================================================
    // Helpers
    // Mid scale: every code bit below the top one set
    function automatic logic [MAX_RES-1:0] mid_scale(input int res);
        mid_scale = MAX_RES'((32'h1 << (res - 1)) - 32'h1);
    endfunction : mid_scale

    // Order in which stored words are copied after power-on
    function automatic logic [4:0] nv_load_addr(input logic [2:0] step);
        case (step)
            3'h0: nv_load_addr = ADDR_CODE_CH0_NV;
            3'h1: nv_load_addr = ADDR_CODE_CH1_NV;
            3'h2: nv_load_addr = ADDR_REFSEL_NV;
            3'h3: nv_load_addr = ADDR_PWRDN_NV;
            default: nv_load_addr = ADDR_GAIN_NV;
        endcase
    endfunction : nv_load_addr

endpackage : dac_cfg_pkg

// ---- hdl/nv_store.sv ----
// Small word store standing in for the nonvolatile array, registered read
`timescale 1ns/1ps
module nv_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock
    input wire logic clk_i,
    // Erase of the programmed marks
    input wire logic clear_i,
    // Access
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic rprog_o
);

    // ==========================================================
    // Storage
    // No reset on purpose: contents must outlive a power-on reset
    logic [WIDTH-1:0] mem [DEPTH];
    logic [DEPTH-1:0] prog;

    // Write and mark the entry programmed
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    // Programmed marks, cleared only by an erase
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            prog <= '0;
        end else if (we_i) begin
            prog[addr_i] <= 1'b1;
        end
    end

    // Registered read
    always_ff @(posedge clk_i) begin
        rdata_o <= mem[addr_i];
        rprog_o <= prog[addr_i];
    end

endmodule : nv_store

// ---- hdl/chan_ref_decode.sv ----
// Per-channel decode of reference, gain and power-down fields into drive controls
`timescale 1ns/1ps
module chan_ref_decode (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Channel fields
    input dac_cfg_pkg::ch_regs_t regs_i,
    // Analogue controls
    output dac_cfg_pkg::ch_drive_t drive_o
);

    // ==========================================================
    // Decode
    dac_cfg_pkg::ch_drive_t next_drive;

    // Field encodings to one-hot controls
    always_comb begin
        next_drive.vdd_ref = (regs_i.refsel == dac_cfg_pkg::REF_VDD); // [R11]
        next_drive.pin_ref = (regs_i.refsel == dac_cfg_pkg::REF_PIN_BUF) ||
                             (regs_i.refsel == dac_cfg_pkg::REF_PIN_UNBUF); // [R11]
        next_drive.bandgap_ref = (regs_i.refsel == dac_cfg_pkg::REF_BANDGAP); // [R11]
        next_drive.ref_buffer_en = (regs_i.refsel == dac_cfg_pkg::REF_PIN_BUF) ||
                                   (regs_i.refsel == dac_cfg_pkg::REF_BANDGAP); // [R11]
        // Supply reference cannot be doubled, so the bit is ignored
        next_drive.gain_2x = regs_i.gain_bit &&
                             (regs_i.refsel != dac_cfg_pkg::REF_VDD); // [R17]
        next_drive.out_enabled = (regs_i.pwrdn == dac_cfg_pkg::PD_NORMAL); // [R16]
        next_drive.pull_1k = (regs_i.pwrdn == dac_cfg_pkg::PD_LOAD_1K); // [R16]
        next_drive.pull_100k = (regs_i.pwrdn == dac_cfg_pkg::PD_LOAD_100K); // [R16]
    end

    // Registered controls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_o <= dac_cfg_pkg::DRIVE_RESET;
        end else begin
            drive_o <= next_drive;
        end
    end

endmodule : chan_ref_decode

// ---- hdl/dac_config_register_bank.sv ----
// Configuration and output-code register bank of a one or two channel DAC
//
// Summary of operation
// (R1) Power-on loads mid-scale codes, clears configuration
// (R2) Power-on sets status flag; status read clears
// (R3) Code field sized to 8, 10 or 12 bits
// (R4) Codes right-aligned, bit zero is code LSB
// (R5) All ones full, zeros zero, mid below top
// (R6) Bits above implemented fields read as zero
// (R7) Channel codes at 00h/10h and 01h/11h
// (R8) Reference select at 08h, stored copy 18h
// (R9) Channel 0 pair bits 1:0, channel 1 3:2
// (R10) Reference register width is twice channel count
// (R11) Reference codes: pin buffered/unbuffered, band gap, supply
// (R12) Band gap stays on whenever selected, even powered-down
// (R13) Host deselects band gap after power-down for economy
// (R14) Host reselects band gap after leaving power-down
// (R15) Two power-down bits per channel, both copies
// (R16) Power-down codes: normal, 1k, 100k, open
// (R17) Gain forced unity when supply is reference
// (R18) Programmed stored words override defaults at power-on
// (R19) Writes to unimplemented bits are discarded
`timescale 1ns/1ps
module dac_config_register_bank #(
    parameter int RESOLUTION = 12,
    parameter int CHANNELS = 2,
    parameter bit NONVOLATILE = 1'b1
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    // Erase pin of the stored words, active low
    input wire logic NV_ERASE_N_I,
    // Register access from the serial front end
    input wire logic [dac_cfg_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [dac_cfg_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [dac_cfg_pkg::DATA_W-1:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    output logic REG_ERR_O,
    // Channel fields and analogue controls
    output dac_cfg_pkg::ch_regs_t [CHANNELS-1:0] CH_REGS_O,
    output dac_cfg_pkg::ch_drive_t [CHANNELS-1:0] CH_DRIVE_O,
    // Status
    output logic BANDGAP_EN_O,
    output logic NV_BUSY_O,
    output logic POR_FLAG_O
);

    // ==========================================================
    // Elaboration checks
    if (!(RESOLUTION == 8 || RESOLUTION == 10 || RESOLUTION == 12) ||
        !(CHANNELS == 1 || CHANNELS == 2)) begin : g_bad_param
        $error("RESOLUTION must be 8, 10 or 12 and CHANNELS 1 or 2");
    end

    // ==========================================================
    // Field masks and defaults
    localparam int REF_W = 2 * CHANNELS; // [R10] [R15]
    localparam logic [15:0] CODE_MASK = 16'((32'h1 << RESOLUTION) - 32'h1); // [R3]
    localparam logic [15:0] PAIR_MASK = 16'((32'h1 << REF_W) - 32'h1); // [R9]
    localparam logic [15:0] GAIN_MASK = 16'(((32'h1 << CHANNELS) - 32'h1) << dac_cfg_pkg::GAIN_LSB);
    localparam logic [11:0] MID = dac_cfg_pkg::mid_scale(RESOLUTION); // [R5]
    localparam logic [15:0] STAT_MASK = GAIN_MASK | 16'(32'h1 << dac_cfg_pkg::POR_BIT)
                                        | 16'(32'h1 << dac_cfg_pkg::BUSY_BIT); // [R6]

    typedef enum {ST_LOAD, ST_READY} load_state_t;

    // Implemented bits of the word at an address
    function automatic logic [15:0] field_mask(input logic [4:0] a);
        case (a)
            dac_cfg_pkg::ADDR_CODE_CH0_V, dac_cfg_pkg::ADDR_CODE_CH1_V,
            dac_cfg_pkg::ADDR_CODE_CH0_NV, dac_cfg_pkg::ADDR_CODE_CH1_NV: field_mask = CODE_MASK;
            dac_cfg_pkg::ADDR_REFSEL_V, dac_cfg_pkg::ADDR_PWRDN_V,
            dac_cfg_pkg::ADDR_REFSEL_NV, dac_cfg_pkg::ADDR_PWRDN_NV: field_mask = PAIR_MASK;
            default: field_mask = GAIN_MASK;
        endcase
    endfunction : field_mask

    // ==========================================================
    // Erase pin synchroniser
    logic erase_meta;
    logic erase_sync;

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            erase_meta <= 1'b1;
            erase_sync <= 1'b1;
        end else begin
            erase_meta <= NV_ERASE_N_I;
            erase_sync <= erase_meta;
        end
    end

    // ==========================================================
    // State
    load_state_t st;
    logic [2:0] step;
    logic apply_valid;
    logic [4:0] apply_addr;
    logic [RESOLUTION-1:0] code_q [CHANNELS];
    logic [REF_W-1:0] refsel_q;
    logic [REF_W-1:0] pwrdn_q;
    logic [CHANNELS-1:0] gain_q;
    logic por_q;
    logic rd_pending;
    logic [4:0] rd_addr;
    logic [15:0] mem_rdata;
    logic mem_rprog;
    logic [15:0] rd_value;
    logic [CHANNELS-1:0] bg_vec;

    // ==========================================================
    // Address decode
    wire busy = (st == ST_LOAD);
    wire two_ch = (CHANNELS == 2);
    wire sel_code0_v = (REG_ADDR_I == dac_cfg_pkg::ADDR_CODE_CH0_V); // [R7]
    wire sel_code1_v = two_ch && (REG_ADDR_I == dac_cfg_pkg::ADDR_CODE_CH1_V); // [R7]
    wire sel_ref_v = (REG_ADDR_I == dac_cfg_pkg::ADDR_REFSEL_V); // [R8]
    wire sel_pd_v = (REG_ADDR_I == dac_cfg_pkg::ADDR_PWRDN_V);
    wire sel_gs_v = (REG_ADDR_I == dac_cfg_pkg::ADDR_GAIN_STAT_V);
    wire sel_nv = NONVOLATILE && ((REG_ADDR_I == dac_cfg_pkg::ADDR_CODE_CH0_NV) ||
                  (two_ch && REG_ADDR_I == dac_cfg_pkg::ADDR_CODE_CH1_NV) ||
                  (REG_ADDR_I == dac_cfg_pkg::ADDR_REFSEL_NV) || // [R8]
                  (REG_ADDR_I == dac_cfg_pkg::ADDR_PWRDN_NV) ||
                  (REG_ADDR_I == dac_cfg_pkg::ADDR_GAIN_NV)); // [R7]
    wire hit = sel_code0_v || sel_code1_v || sel_ref_v || sel_pd_v || sel_gs_v || sel_nv;
    // Nothing is accepted while the stored words are being copied
    wire host_wr_ok = REG_WR_I && !busy && hit;
    wire host_rd_ok = REG_RD_I && !busy && hit;
    wire refused = (REG_WR_I || REG_RD_I) && !(hit && !busy);

    // Volatile write path shared by host and power-on copy
    wire load_we = apply_valid && mem_rprog; // [R18]
    wire vol_we = (host_wr_ok && !sel_nv) || load_we;
    wire [4:0] vol_addr = busy ? {1'b0, apply_addr[3:0]} : REG_ADDR_I;
    wire [15:0] vol_wdata = busy ? mem_rdata : REG_WDATA_I;

    // Store port: copy sequence while busy, host otherwise
    wire [4:0] load_addr = dac_cfg_pkg::nv_load_addr(step);
    wire mem_we = host_wr_ok && sel_nv;
    wire [3:0] mem_addr = busy ? load_addr[3:0] : REG_ADDR_I[3:0];
    wire [15:0] mem_wdata = REG_WDATA_I & field_mask(REG_ADDR_I); // [R19]

    nv_store #(
        .WIDTH(dac_cfg_pkg::DATA_W),
        .DEPTH(dac_cfg_pkg::NV_DEPTH)
    ) u_store (
        .clk_i(CORE_CLK_I),
        .clear_i(!erase_sync),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata),
        .rprog_o(mem_rprog)
    );

    // ==========================================================
    // Power-on copy sequence
    // Reads entry step while applying entry step-1, one word per cycle
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st <= ST_LOAD;
            step <= 3'h0;
            apply_valid <= 1'b0;
            apply_addr <= 5'h00;
        end else begin
            apply_valid <= busy && NONVOLATILE && (step < dac_cfg_pkg::NV_LOAD_COUNT);
            apply_addr <= load_addr;
            case (st)
                ST_LOAD: begin
                    step <= step + 3'h1;
                    if (!NONVOLATILE || step == dac_cfg_pkg::NV_LOAD_COUNT) begin
                        st <= ST_READY;
                    end
                end
                ST_READY: begin
                    step <= 3'h0;
                end
                default: begin
                    st <= ST_LOAD;
                end
            endcase
        end
    end

    // ==========================================================
    // Per-channel code registers and decode
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        wire code_we = vol_we && (vol_addr == 5'(dac_cfg_pkg::ADDR_CODE_CH0_V + i));

        // Right-aligned code, mid scale at power-on
        always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                code_q[i] <= MID[RESOLUTION-1:0]; // [R1] [R5]
            end else if (code_we) begin
                code_q[i] <= vol_wdata[RESOLUTION-1:0]; // [R4] [R19]
            end
        end

        assign CH_REGS_O[i].code = 12'(code_q[i]); // [R4]
        assign CH_REGS_O[i].refsel = dac_cfg_pkg::refsel_t'(refsel_q[2*i +: 2]); // [R9]
        assign CH_REGS_O[i].pwrdn = dac_cfg_pkg::pwrdn_t'(pwrdn_q[2*i +: 2]); // [R15]
        assign CH_REGS_O[i].gain_bit = gain_q[i];
        // Band gap request ignores power-down entirely
        assign bg_vec[i] = (refsel_q[2*i +: 2] == dac_cfg_pkg::REF_BANDGAP); // [R12]

        chan_ref_decode u_dec (
            .clk_i(CORE_CLK_I),
            .rst_n_i(RESET_N_I),
            .regs_i(CH_REGS_O[i]),
            .drive_o(CH_DRIVE_O[i])
        );
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            refsel_q <= dac_cfg_pkg::CFG_RESET[REF_W-1:0]; // [R1]
            pwrdn_q <= dac_cfg_pkg::CFG_RESET[REF_W-1:0]; // [R1]
            gain_q <= dac_cfg_pkg::CFG_RESET[CHANNELS-1:0]; // [R1]
        end else if (vol_we) begin
            if (vol_addr == dac_cfg_pkg::ADDR_REFSEL_V) begin
                refsel_q <= vol_wdata[REF_W-1:0]; // [R10] [R19]
            end
            if (vol_addr == dac_cfg_pkg::ADDR_PWRDN_V) begin
                pwrdn_q <= vol_wdata[REF_W-1:0]; // [R15] [R19]
            end
            if (vol_addr == dac_cfg_pkg::ADDR_GAIN_STAT_V) begin
                gain_q <= vol_wdata[dac_cfg_pkg::GAIN_LSB +: CHANNELS]; // [R19]
            end
        end
    end

    // Status flag: reset is its only set, so no set/clear race exists
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            por_q <= 1'b1; // [R2]
        end else if (rd_pending && rd_addr == dac_cfg_pkg::ADDR_GAIN_STAT_V) begin
            por_q <= 1'b0; // [R2]
        end
    end

    // ==========================================================
    // Read data composition, zeros above every field
    always_comb begin
        rd_value = 16'h0000;
        case (rd_addr)
            dac_cfg_pkg::ADDR_CODE_CH0_V: rd_value = 16'(code_q[0]); // [R6]
            dac_cfg_pkg::ADDR_CODE_CH1_V: rd_value = 16'(code_q[CHANNELS-1]); // [R6]
            dac_cfg_pkg::ADDR_REFSEL_V: rd_value = 16'(refsel_q); // [R6]
            dac_cfg_pkg::ADDR_PWRDN_V: rd_value = 16'(pwrdn_q);
            dac_cfg_pkg::ADDR_GAIN_STAT_V: begin
                rd_value[dac_cfg_pkg::GAIN_LSB +: CHANNELS] = gain_q;
                rd_value[dac_cfg_pkg::POR_BIT] = por_q; // [R2]
                rd_value[dac_cfg_pkg::BUSY_BIT] = busy;
            end
            default: begin
                // Unprogrammed stored words read back their defaults
                if (mem_rprog) begin
                    rd_value = mem_rdata & field_mask(rd_addr); // [R6]
                end else if (field_mask(rd_addr) == CODE_MASK) begin
                    rd_value = 16'(MID[RESOLUTION-1:0]);
                end
            end
        endcase
    end

    // Two-cycle read answer, one-cycle refusal flag
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_pending <= 1'b0;
            rd_addr <= 5'h00;
            REG_RDATA_O <= 16'h0000;
            REG_RVALID_O <= 1'b0;
            REG_ERR_O <= 1'b0;
            BANDGAP_EN_O <= 1'b0;
        end else begin
            rd_pending <= host_rd_ok;
            rd_addr <= REG_ADDR_I;
            REG_RVALID_O <= rd_pending;
            REG_ERR_O <= refused;
            BANDGAP_EN_O <= |bg_vec; // [R12]
            if (rd_pending) begin
                REG_RDATA_O <= rd_value;
            end
        end
    end

    assign NV_BUSY_O = busy;
    assign POR_FLAG_O = por_q;

    // ==========================================================
    // Assertions
    sequence s_status_read;
        host_rd_ok && REG_ADDR_I == dac_cfg_pkg::ADDR_GAIN_STAT_V;
    endsequence

    property p_por_clear;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        s_status_read |-> ##2 (!POR_FLAG_O && REG_RVALID_O);
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("status flag not cleared by read"); // [R2]

    property p_reset_state;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (busy && step == 3'h0) |-> (code_q[0] == MID[RESOLUTION-1:0] && refsel_q == '0
                                   && pwrdn_q == '0 && gain_q == '0 && por_q);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("power-on values wrong"); // [R1]

    // Channel 0 code reads and status reads each checked against their own field set
    property p_code_zero_top;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        ((host_rd_ok && sel_code0_v) |-> ##2 ((REG_RDATA_O & ~CODE_MASK) == 16'h0000))
        and (s_status_read |-> ##2 ((REG_RDATA_O & ~STAT_MASK) == 16'h0000));
    endproperty
    a_code_zero_top: assert property (p_code_zero_top) else $error("unimplemented bits set"); // [R6]
    property p_ref_read;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (host_rd_ok && sel_ref_v) |-> ##2 (REG_RDATA_O == 16'($past(refsel_q, 1)));
    endproperty
    a_ref_read: assert property (p_ref_read) else $error("reference read wrong"); // [R9]
    property p_code_write;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (host_wr_ok && sel_code0_v) |=> (CH_REGS_O[0].code == 12'($past(REG_WDATA_I) & CODE_MASK));
    endproperty
    a_code_write: assert property (p_code_write) else $error("code write wrong"); // [R4]
    property p_bandgap;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (CH_REGS_O[0].refsel == dac_cfg_pkg::REF_BANDGAP) |=> BANDGAP_EN_O;
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("band gap dropped"); // [R12]
    property p_gain_vdd;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (CH_REGS_O[0].refsel == dac_cfg_pkg::REF_VDD) |=> !CH_DRIVE_O[0].gain_2x;
    endproperty
    a_gain_vdd: assert property (p_gain_vdd) else $error("gain not forced to unity"); // [R17]
    // A copy step may legally move the register, so only idle copy cycles are judged
    property p_busy_refuse;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (busy && REG_WR_I && !load_we) |=> (REG_ERR_O && $stable(refsel_q));
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("access taken while busy"); // [R18]
    property p_load_ends;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        busy |-> ##[0:7] !busy;
    endproperty
    a_load_ends: assert property (p_load_ends) else $error("power-on copy too long"); // [R18]

endmodule : dac_config_register_bank

// ---- dv/reg_host.sv ----
// Host model issuing register reads and writes to the bank
`timescale 1ns/1ps
module reg_host (
    // Clock
    input wire logic clk_i,
    // Request side
    output logic [4:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    // Answer side
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic err_i
);
    // ==========
    // Bus cycles
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = '0;
    end
    // Idle lines flip so a stale value never looks valid
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr
    // Refusal shows one cycle on, data two
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v,
                      output logic e);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        e = err_i;
        @(negedge clk_i);
        v = rvalid_i;
        d = rdata_i;
    endtask : rd
    // Drop band gap once powered down, for least current
    task automatic bg_off();
        wr(5'h08, 16'h0000);
    endtask : bg_off
    task automatic bg_on();
        wr(5'h09, 16'h0000);
        wr(5'h08, 16'h0001);
    endtask : bg_on
endmodule : reg_host

// ---- dv/dac_config_register_bank_tb.sv ----
// Self-checking bench of the DAC register bank
`timescale 1ns/1ps
module dac_config_register_bank_tb;
    logic clk = 0, rst_n = 0, erase_n = 0;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, d;
    logic wr, rd, rvalid, err, bg, busy, por, v, e;
    dac_cfg_pkg::ch_regs_t [1:0] regs;
    dac_cfg_pkg::ch_drive_t [1:0] drv;
    int errors = 0, n_compared = 0, cycles = 0;
    // ==========
    // Clock, watchdog
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            tally_and_finish();
        end
    end
    dac_config_register_bank dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .NV_ERASE_N_I(erase_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REG_ERR_O(err),
        .CH_REGS_O(regs), .CH_DRIVE_O(drv), .BANDGAP_EN_O(bg), .NV_BUSY_O(busy),
        .POR_FLAG_O(por));
    reg_host host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata), .rvalid_i(rvalid), .err_i(err));
    // ==========
    // Checks
    task automatic chk(string n, logic [15:0] x, logic [15:0] g);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic rchk(logic [4:0] a, logic [15:0] x);
        host.rd(a, d, v, e);
        chk("rvalid", 16'h1, 16'(v));
        chk($sformatf("reg %h", a), x, d);
    endtask : rchk
    // Power-on copy needs six edges after release
    task automatic por_cycle();
        @(negedge clk);
        rst_n = 0;
        repeat (6) @(negedge clk);
        rst_n = 1;
        host.wr(5'h08, 16'h0003);
        chk("busy err", 16'h1, 16'(err));
        repeat (8) @(negedge clk);
        chk("busy", 16'h0, 16'(busy));
    endtask : por_cycle
    task automatic tally_and_finish();
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // ==========
    // Sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        repeat (6) @(negedge clk);
        erase_n = 1;
        por_cycle();
        chk("por flag", 16'h1, 16'(por));
        rchk(5'h00, 16'h07ff);
        rchk(5'h01, 16'h07ff);
        rchk(5'h08, 16'h0000);
        rchk(5'h09, 16'h0000);
        rchk(5'h0a, 16'h0080);
        rchk(5'h0a, 16'h0000);
        host.wr(5'h00, 16'hffff);
        rchk(5'h00, 16'h0fff);
        chk("code", 16'h0fff, 16'(regs[0].code));
        host.wr(5'h01, 16'h0000);
        rchk(5'h01, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            host.wr(5'h08, 16'hfff0 | 16'(c * 5));
            rchk(5'h08, 16'(c * 5));
            host.wr(5'h09, 16'hfff0 | 16'(c * 5));
            rchk(5'h09, 16'(c * 5));
            chk("pd", 16'({c == 0, c == 1, c == 2}),
                16'({drv[0].out_enabled, drv[0].pull_1k, drv[0].pull_100k}));
        end
        host.wr(5'h08, 16'h0001);
        repeat (2) @(negedge clk);
        chk("bg pd", 16'h1, 16'(bg));
        host.bg_off();
        repeat (2) @(negedge clk);
        chk("bg off", 16'h0, 16'(bg));
        host.bg_on();
        rchk(5'h08, 16'h0001);
        host.wr(5'h08, 16'h0000);
        host.wr(5'h0a, 16'h0100);
        repeat (2) @(negedge clk);
        chk("gain vdd", 16'h0, 16'(drv[0].gain_2x));
        host.wr(5'h08, 16'h0003);
        repeat (2) @(negedge clk);
        chk("gain pin", 16'h1, 16'(drv[0].gain_2x));
        host.rd(5'h02, d, v, e);
        chk("refused", 16'h2, 16'({e, v}));
        host.wr(5'h10, 16'hfabc);
        host.wr(5'h18, 16'h0002);
        rchk(5'h10, 16'h0abc);
        por_cycle();
        rchk(5'h00, 16'h0abc);
        rchk(5'h01, 16'h07ff);
        rchk(5'h08, 16'h0002);
        rchk(5'h0a, 16'h0080);
        tally_and_finish();
    end
endmodule : dac_config_register_bank_tb
